// ===== verilog/pltc_pkg.sv
// Shared constants: management map, fields, unlock codes and APB map.
// Assumes one clock with a synchronous reset.
package pltc_pkg;

    // ========================================================================
    // Management register map and fields
    localparam int MGMT_AW = 5;
    localparam int MGMT_DW = 16;
    localparam logic [4:0] MREG_BASIC = 5'h00;
    localparam logic [4:0] MREG_MODE_UNLOCK = 5'h14;
    localparam logic [4:0] MREG_WAVE_TRIM = 5'h17;
    localparam int BASIC_SW_RESET = 15;
    localparam int BASIC_LOOPBACK = 14;
    localparam int BASIC_SPEED100 = 13;
    localparam int BASIC_ANEG_RESTART = 9;
    localparam int BASIC_FULL_DUPLEX = 8;
    localparam int BASIC_COLL_TEST = 7;
    localparam logic [15:0] BASIC_RESET = 16'h3000;
    localparam logic [15:0] BASIC_SELF_CLEAR = 16'h8200;

    // ========================================================================
    // Waveform trim unlock codes and defaults
    localparam logic [15:0] UNLOCK_KEY = 16'h4400;
    localparam logic [15:0] COMMIT_TX100 = 16'h4416;
    localparam logic [15:0] COMMIT_TX10 = 16'h4418;
    localparam logic [15:0] TRIM100_DEFAULT = 16'h0000;
    localparam logic [15:0] TRIM10_DEFAULT = 16'h0000;
    localparam logic [15:0] MODE_REG_RESET = 16'h0000;
    // Tx100 trim layout: amplitude [15:12], slope 2 bits per range [11:4], shift 1 bit per range [3:0].
    localparam int T100_AMP_LSB = 12;
    localparam int T100_SLOPE_LSB = 4;
    localparam int T100_SHIFT_LSB = 0;
    // Tx10 trim layout: amplitude [15:14], slope [13:12].
    localparam int T10_AMP_LSB = 14;
    localparam int T10_SLOPE_LSB = 12;

    typedef enum logic [1:0] {
        UNL_IDLE = 2'b00,
        UNL_KEYED = 2'b01,
        UNL_DATA = 2'b10
    } pltc_unlock_t;

    // ========================================================================
    // Scrambler
    localparam int LFSR_W = 11;
    localparam logic [5:0] SEED_HIGH = 6'h3f;

    // ========================================================================
    // Controller APB map
    localparam logic [7:0] APB_CTRL = 8'h00;
    localparam logic [7:0] APB_ADDR = 8'h04;
    localparam logic [7:0] APB_CMD = 8'h08;
    localparam logic [7:0] APB_WDATA = 8'h0c;
    localparam logic [7:0] APB_RDATA = 8'h10;
    localparam logic [15:0] CTRL_RESET = 16'hc000;
    localparam int CTRL_MRST_N = 14;
    localparam int CTRL_MODE_LSB = 0;
    localparam int MODE_W = 2;
    localparam int CMD_GO = 31;
    localparam int CMD_WRITE = 8;
    localparam int RDATA_BUSY = 16;

    typedef enum logic [1:0] {
        CTL_IDLE = 2'b00,
        CTL_REQ = 2'b01,
        CTL_WAIT = 2'b10
    } pltc_ctl_t;

endpackage

// ===== verilog/pltc_if.sv
// Interface joining the transceiver end and the controller end.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface pltc_if;
    // Management
    logic [4:0] mgmt_addr;
    logic [15:0] mgmt_wdata;
    logic mgmt_wr;
    logic mgmt_rd;
    logic [15:0] mgmt_rdata;
    logic mgmt_ack;
    // Interface control
    logic module_reset_n;
    logic [1:0] digital_block_mode_select;
    logic [4:0] iface_station_address_reg;
    // MAC data path
    logic mac_transmit_enable;
    logic [3:0] mac_tx_data;
    logic mac_rx_valid;
    logic [3:0] mac_rx_data;
    logic collision_out;

    modport phy_end (
        input mgmt_addr, mgmt_wdata, mgmt_wr, mgmt_rd,
        output mgmt_rdata, mgmt_ack,
        input module_reset_n, digital_block_mode_select, iface_station_address_reg,
        input mac_transmit_enable, mac_tx_data,
        output mac_rx_valid, mac_rx_data, collision_out
    );
    modport ctrl_end (
        output mgmt_addr, mgmt_wdata, mgmt_wr, mgmt_rd,
        input mgmt_rdata, mgmt_ack,
        output module_reset_n, digital_block_mode_select, iface_station_address_reg,
        output mac_transmit_enable, mac_tx_data,
        input mac_rx_valid, mac_rx_data, collision_out
    );
endinterface

// ===== verilog/pltc_ctrl_end.sv
// Controller end: APB registers, management command engine, MAC forwarding.
// Assumes the transceiver end on the interface.
`timescale 1ns/1ps
module pltc_ctrl_end (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // MAC user side
    input wire logic mac_tx_en_in,
    input wire logic [3:0] mac_tx_data_in,
    output logic mac_rx_valid_out,
    output logic [3:0] mac_rx_data_out,
    output logic mac_collision_out,
    // Link to the transceiver
    pltc_if.ctrl_end link
);
    // ========================================================================
    // Registers
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [4:0] addr_r, addr_nxt;
    logic [4:0] cmd_addr_r, cmd_addr_nxt;
    logic cmd_write_r, cmd_write_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    pltc_pkg::pltc_ctl_t st_r, st_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic tx_en_r;
    logic [3:0] tx_data_r;
    logic rx_valid_r;
    logic [3:0] rx_data_r;
    logic coll_r;
    logic wr_en;
    logic rd_en;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        addr_nxt = addr_r;
        cmd_addr_nxt = cmd_addr_r;
        cmd_write_nxt = cmd_write_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        st_nxt = st_r;
        prdata_nxt = prdata_r;
        if (wr_en) begin
            unique case (paddr)
                pltc_pkg::APB_CTRL: ctrl_nxt = pwdata[15:0];
                // Station address; the transceiver latches it only during reset and management uses the CMD address.
                pltc_pkg::APB_ADDR: addr_nxt = pwdata[4:0];
                pltc_pkg::APB_WDATA: wdata_nxt = pwdata[15:0];
                pltc_pkg::APB_CMD: begin
                    // A new command while one is in flight is dropped.
                    if (pwdata[pltc_pkg::CMD_GO] && st_r == pltc_pkg::CTL_IDLE) begin
                        cmd_addr_nxt = pwdata[4:0];
                        cmd_write_nxt = pwdata[pltc_pkg::CMD_WRITE];
                        st_nxt = pltc_pkg::CTL_REQ;
                    end
                end
                default: ;
            endcase
        end
        if (rd_en) begin
            unique case (paddr)
                pltc_pkg::APB_CTRL: prdata_nxt = {16'h0000, ctrl_r};
                pltc_pkg::APB_ADDR: prdata_nxt = {27'h0000000, addr_r};
                pltc_pkg::APB_CMD: prdata_nxt = {23'h000000, cmd_write_r, 3'h0, cmd_addr_r};
                pltc_pkg::APB_WDATA: prdata_nxt = {16'h0000, wdata_r};
                pltc_pkg::APB_RDATA: prdata_nxt = {15'h0000, (st_r != pltc_pkg::CTL_IDLE), rdata_r};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
        unique case (st_r)
            pltc_pkg::CTL_IDLE: ;
            pltc_pkg::CTL_REQ: st_nxt = pltc_pkg::CTL_WAIT;
            pltc_pkg::CTL_WAIT: begin
                if (link.mgmt_ack) begin
                    if (!cmd_write_r) begin
                        rdata_nxt = link.mgmt_rdata;
                    end
                    st_nxt = pltc_pkg::CTL_IDLE;
                end
            end
            default: st_nxt = pltc_pkg::CTL_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= pltc_pkg::CTRL_RESET;
            addr_r <= 5'h00;
            cmd_addr_r <= 5'h00;
            cmd_write_r <= 1'b0;
            wdata_r <= 16'h0000;
            rdata_r <= 16'h0000;
            st_r <= pltc_pkg::CTL_IDLE;
            prdata_r <= 32'h00000000;
            tx_en_r <= 1'b0;
            tx_data_r <= 4'h0;
            rx_valid_r <= 1'b0;
            rx_data_r <= 4'h0;
            coll_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            addr_r <= addr_nxt;
            cmd_addr_r <= cmd_addr_nxt;
            cmd_write_r <= cmd_write_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            st_r <= st_nxt;
            prdata_r <= prdata_nxt;
            tx_en_r <= mac_tx_en_in;
            tx_data_r <= mac_tx_data_in;
            rx_valid_r <= link.mac_rx_valid;
            rx_data_r <= link.mac_rx_data;
            coll_r <= link.collision_out;
        end
    end

    // ========================================================================
    // Link drive
    assign link.mgmt_addr = cmd_addr_r;
    assign link.mgmt_wdata = wdata_r;
    assign link.mgmt_wr = (st_r == pltc_pkg::CTL_REQ) && cmd_write_r;
    assign link.mgmt_rd = (st_r == pltc_pkg::CTL_REQ) && !cmd_write_r;
    // Transceiver reset goes through this bit, never the self-clearing one.
    assign link.module_reset_n = ctrl_r[pltc_pkg::CTRL_MRST_N];
    assign link.digital_block_mode_select = ctrl_r[pltc_pkg::CTRL_MODE_LSB +: pltc_pkg::MODE_W];
    assign link.iface_station_address_reg = addr_r;
    assign link.mac_transmit_enable = tx_en_r;
    assign link.mac_tx_data = tx_data_r;
    assign mac_rx_valid_out = rx_valid_r;
    assign mac_rx_data_out = rx_data_r;
    assign mac_collision_out = coll_r;
endmodule // pltc_ctrl_end

// ===== verilog/pltc_phy_end.sv
// Transceiver end: management registers, trims, loopback and collision.
// Assumes the controller end on the interface and same-clock line data.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - Basic control bit 14 selects internal loopback.
// - Loopback feeds scrambler output into descrambler.
// - Loopback holds collision low unless collision test.
// - Loopback transmits nothing, line drivers powered down.
// - Station address captured only during reset.
// - Latched station address seeds the scrambler.
// - Digital block mode comes from control register.
// - Software resets via module reset, not bit 15.
// - Registers 20 and 23 guarded by unlock sequence.
// - Trims return to default on autoneg, reset.
// - Commit code 4418 stores data as Tx10 trim.
// - Tx10 bits 15:14 amplitude, 13:12 slope.
// - Unlock accepted only while running at 100 Mb/s.
// - Tx100 four time ranges, per-range shift, slope.
// - Transceiver clock must be the fixed rate.
// - Collision test follows transmit enable.
module pltc_phy_end (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller link
    pltc_if.phy_end link,
    // Line side
    input wire logic line_rx_valid,
    input wire logic [3:0] line_rx_data,
    output logic line_tx_valid,
    output logic [3:0] line_tx_data,
    output logic line_tx_power_up,
    // Applied configuration and waveform trims
    output logic loopback_active,
    output logic [1:0] digital_mode_applied,
    output logic [1:0] tx100_range,
    output logic tx100_time_shift,
    output logic [1:0] tx100_slope_trim,
    output logic [3:0] tx100_amplitude_trim,
    output logic [1:0] tx10_amplitude_trim,
    output logic [1:0] tx10_slope_trim
);
    function automatic logic [10:0] lfsr_step(input logic [10:0] s);
        lfsr_step = {s[9:0], s[10] ^ s[8]};
    endfunction

    // ========================================================================
    // Reset and captured configuration
    logic grst;
    logic [4:0] station_r, station_nxt;
    logic [1:0] mode_sel_r, mode_sel_nxt;
    logic [10:0] seed;

    assign grst = rst || !link.module_reset_n;

    always_comb begin
        station_nxt = station_r;
        mode_sel_nxt = mode_sel_r;
        if (grst) begin
            station_nxt = link.iface_station_address_reg;
            mode_sel_nxt = link.digital_block_mode_select;
        end
    end

    always_ff @(posedge clk) begin
        station_r <= station_nxt;
        mode_sel_r <= mode_sel_nxt;
    end

    assign seed = {pltc_pkg::SEED_HIGH, station_r};
    assign digital_mode_applied = mode_sel_r;

    // ========================================================================
    // Management registers and the trim unlock sequence
    logic [15:0] basic_r, basic_nxt;
    logic [15:0] modereg_r, modereg_nxt;
    logic [15:0] pend_r, pend_nxt;
    logic [15:0] trim100_r, trim100_nxt;
    logic [15:0] trim10_r, trim10_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    pltc_pkg::pltc_unlock_t unl_r, unl_nxt;
    logic wr_mode;
    logic wr_trim;

    assign wr_mode = link.mgmt_wr && link.mgmt_addr == pltc_pkg::MREG_MODE_UNLOCK;
    assign wr_trim = link.mgmt_wr && link.mgmt_addr == pltc_pkg::MREG_WAVE_TRIM;

    always_comb begin
        basic_nxt = basic_r;
        modereg_nxt = modereg_r;
        pend_nxt = pend_r;
        trim100_nxt = trim100_r;
        trim10_nxt = trim10_r;
        rdata_nxt = rdata_r;
        unl_nxt = unl_r;
        ack_nxt = link.mgmt_wr || link.mgmt_rd;
        if (wr_mode) begin
            modereg_nxt = link.mgmt_wdata;
        end
        // A single stray write only moves the sequence back to idle.
        unique case (unl_r)
            pltc_pkg::UNL_IDLE: begin
                if (wr_mode && link.mgmt_wdata == pltc_pkg::UNLOCK_KEY
                        && basic_r[pltc_pkg::BASIC_SPEED100]) begin
                    unl_nxt = pltc_pkg::UNL_KEYED;
                end
            end
            pltc_pkg::UNL_KEYED: begin
                if (wr_trim) begin
                    pend_nxt = link.mgmt_wdata;
                    unl_nxt = pltc_pkg::UNL_DATA;
                end else if (link.mgmt_wr) begin
                    unl_nxt = pltc_pkg::UNL_IDLE;
                end
            end
            pltc_pkg::UNL_DATA: begin
                if (link.mgmt_wr) begin
                    unl_nxt = pltc_pkg::UNL_IDLE;
                end
                if (wr_mode && link.mgmt_wdata == pltc_pkg::COMMIT_TX100) begin
                    trim100_nxt = pend_r;
                end
                if (wr_mode && link.mgmt_wdata == pltc_pkg::COMMIT_TX10) begin
                    trim10_nxt = pend_r;
                end
            end
            default: unl_nxt = pltc_pkg::UNL_IDLE;
        endcase
        if (link.mgmt_wr && link.mgmt_addr == pltc_pkg::MREG_BASIC) begin
            // The software reset bit is accepted but does nothing here.
            basic_nxt = link.mgmt_wdata & ~pltc_pkg::BASIC_SELF_CLEAR;
            if (link.mgmt_wdata[pltc_pkg::BASIC_ANEG_RESTART]) begin
                trim100_nxt = pltc_pkg::TRIM100_DEFAULT;
                trim10_nxt = pltc_pkg::TRIM10_DEFAULT;
                unl_nxt = pltc_pkg::UNL_IDLE;
            end
        end
        if (link.mgmt_rd) begin
            unique case (link.mgmt_addr)
                pltc_pkg::MREG_BASIC: rdata_nxt = basic_r;
                pltc_pkg::MREG_MODE_UNLOCK: rdata_nxt = modereg_r;
                pltc_pkg::MREG_WAVE_TRIM: rdata_nxt = trim100_r;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (grst) begin
            basic_r <= pltc_pkg::BASIC_RESET;
            modereg_r <= pltc_pkg::MODE_REG_RESET;
            pend_r <= 16'h0000;
            trim100_r <= pltc_pkg::TRIM100_DEFAULT;
            trim10_r <= pltc_pkg::TRIM10_DEFAULT;
            rdata_r <= 16'h0000;
            ack_r <= 1'b0;
            unl_r <= pltc_pkg::UNL_IDLE;
        end else begin
            basic_r <= basic_nxt;
            modereg_r <= modereg_nxt;
            pend_r <= pend_nxt;
            trim100_r <= trim100_nxt;
            trim10_r <= trim10_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
            unl_r <= unl_nxt;
        end
    end

    assign link.mgmt_rdata = rdata_r;
    assign link.mgmt_ack = ack_r;

    // ========================================================================
    // Data path: scrambler, loopback, descrambler, collision
    logic lb;
    logic [10:0] scr_r, scr_nxt;
    logic [10:0] dsc_r, dsc_nxt;
    logic [3:0] scr_data_r, scr_data_nxt;
    logic scr_valid_r, scr_valid_nxt;
    logic [3:0] rxd_r, rxd_nxt;
    logic rxv_r, rxv_nxt;
    logic coll_r, coll_nxt;
    logic [1:0] range_r, range_nxt;
    logic din_valid;
    logic [3:0] din_data;

    assign lb = basic_r[pltc_pkg::BASIC_LOOPBACK];
    assign din_valid = lb ? scr_valid_r : line_rx_valid;
    assign din_data = lb ? scr_data_r : line_rx_data;

    always_comb begin
        scr_nxt = link.mac_transmit_enable ? lfsr_step(scr_r) : seed;
        scr_valid_nxt = link.mac_transmit_enable;
        scr_data_nxt = link.mac_transmit_enable ? (link.mac_tx_data ^ scr_r[3:0]) : 4'h0;
        dsc_nxt = din_valid ? lfsr_step(dsc_r) : seed;
        rxv_nxt = din_valid;
        rxd_nxt = din_valid ? (din_data ^ dsc_r[3:0]) : 4'h0;
        if (basic_r[pltc_pkg::BASIC_COLL_TEST]) begin
            coll_nxt = link.mac_transmit_enable;
        end else if (lb || basic_r[pltc_pkg::BASIC_FULL_DUPLEX]) begin
            coll_nxt = 1'b0;
        end else begin
            coll_nxt = link.mac_transmit_enable && line_rx_valid;
        end
        range_nxt = scr_valid_r ? range_r + 2'h1 : 2'h0;
    end

    always_ff @(posedge clk) begin
        if (grst) begin
            scr_r <= {pltc_pkg::LFSR_W{1'b1}};
            dsc_r <= {pltc_pkg::LFSR_W{1'b1}};
            scr_data_r <= 4'h0;
            scr_valid_r <= 1'b0;
            rxd_r <= 4'h0;
            rxv_r <= 1'b0;
            coll_r <= 1'b0;
            range_r <= 2'h0;
        end else begin
            scr_r <= scr_nxt;
            dsc_r <= dsc_nxt;
            scr_data_r <= scr_data_nxt;
            scr_valid_r <= scr_valid_nxt;
            rxd_r <= rxd_nxt;
            rxv_r <= rxv_nxt;
            coll_r <= coll_nxt;
            range_r <= range_nxt;
        end
    end

    assign link.mac_rx_valid = rxv_r;
    assign link.mac_rx_data = rxd_r;
    assign link.collision_out = coll_r;
    assign line_tx_valid = scr_valid_r && !lb;
    assign line_tx_data = lb ? 4'h0 : scr_data_r;
    assign line_tx_power_up = !lb && !grst;
    assign loopback_active = lb;

    // ========================================================================
    // Trim outputs
    assign tx100_range = range_r;
    assign tx100_time_shift = trim100_r[pltc_pkg::T100_SHIFT_LSB + range_r];
    assign tx100_slope_trim = trim100_r[pltc_pkg::T100_SLOPE_LSB + 2 * range_r +: 2];
    assign tx100_amplitude_trim = trim100_r[pltc_pkg::T100_AMP_LSB +: 4];
    assign tx10_amplitude_trim = trim10_r[pltc_pkg::T10_AMP_LSB +: 2];
    assign tx10_slope_trim = trim10_r[pltc_pkg::T10_SLOPE_LSB +: 2];
endmodule // pltc_phy_end

// ===== test/pltc_sva.sv
// Checker on the link between the two ends.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pltc_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Management link
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic mgmt_ack,
    input wire logic module_reset_n,
    // MAC data path
    input wire logic mac_transmit_enable,
    input wire logic [3:0] mac_tx_data,
    input wire logic mac_rx_valid,
    input wire logic [3:0] mac_rx_data,
    input wire logic collision_out
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ====================================================================
    // Mirror of the loopback and collision test bits
    // The old copies match the far end's extra register.
    logic loop_r, coll_r, loop_old_r, coll_old_r;
    always_ff @(posedge clk) begin
        loop_old_r <= rst ? 1'b0 : loop_r;
        coll_old_r <= rst ? 1'b0 : coll_r;
        if (rst || !module_reset_n) begin
            loop_r <= 1'b0;
            coll_r <= 1'b0;
        end else if (mgmt_wr && mgmt_addr == pltc_pkg::MREG_BASIC) begin
            loop_r <= mgmt_wdata[pltc_pkg::BASIC_LOOPBACK];
            coll_r <= mgmt_wdata[pltc_pkg::BASIC_COLL_TEST];
        end
    end

    // ====================================================================
    // Assertions
    chk_mgmt_answer: assert property ((mgmt_wr || mgmt_rd) |=> mgmt_ack ##1 !mgmt_ack)
        else $error("no single ack");
    chk_ack_cause: assert property (mgmt_ack |-> $past(mgmt_wr || mgmt_rd))
        else $error("stray ack");
    chk_strobe_single: assert property (mgmt_wr |=> !mgmt_wr && !mgmt_rd)
        else $error("requests back to back");
    chk_mrst_release: assert property ($fell(rst) |-> module_reset_n)
        else $error("module reset stuck");
    chk_loop_no_coll: assert property (loop_old_r && !coll_old_r |-> !collision_out)
        else $error("loopback collision");
    chk_coll_test_on: assert property (coll_r && mac_transmit_enable |-> ##[1:2] collision_out)
        else $error("collision test missed");
    chk_coll_test_off: assert property (coll_r && !mac_transmit_enable |-> ##[1:2] !collision_out)
        else $error("collision test stuck");
    chk_loop_echo: assert property (loop_r && loop_old_r && mac_transmit_enable |->
        ##2 (mac_rx_valid && mac_rx_data == $past(mac_tx_data, 2)))
        else $error("loopback data lost");
    chk_loop_quiet: assert property (loop_r && loop_old_r && !mac_transmit_enable |-> ##2 !mac_rx_valid)
        else $error("loopback receive leak");
    cover property (loop_r && mac_rx_valid);
    cover property (coll_r && collision_out);
    cover property (mgmt_wr && mgmt_addr == pltc_pkg::MREG_WAVE_TRIM);
endmodule // pltc_sva

// ===== test/testbench.sv
// Self-checking bench for both ends, driven over APB and the MAC side.
// Assumes the package and interface are compiled first.
`timescale 1ns/1ps
`define CMP(g, e) begin compares++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic tx_en, rx_v, coll, lrx_v, ltx_v, ltx_pwr, loop_a, shift;
    logic [3:0] tx_d, rx_d, lrx_d, ltx_d, amp100, exp_nib;
    logic [1:0] mode_app, range, slope, amp10, slope10, m;
    logic [15:0] v, d, t100;
    logic [3:0] rxq[$];
    logic [4:0] sa;
    int fails, compares;
    localparam logic [4:0] BC = pltc_pkg::MREG_BASIC, MU = pltc_pkg::MREG_MODE_UNLOCK, WT = pltc_pkg::MREG_WAVE_TRIM;
    localparam logic [7:0] CT = pltc_pkg::APB_CTRL;
    pltc_if link ();
    pltc_ctrl_end pltc_ctrl_end_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mac_tx_en_in(tx_en), .mac_tx_data_in(tx_d), .mac_rx_valid_out(rx_v), .mac_rx_data_out(rx_d),
        .mac_collision_out(coll), .link(link));
    pltc_phy_end pltc_phy_end_inst (.clk(clk), .rst(rst), .link(link), .line_rx_valid(lrx_v),
        .line_rx_data(lrx_d), .line_tx_valid(ltx_v), .line_tx_data(ltx_d), .line_tx_power_up(ltx_pwr),
        .loopback_active(loop_a), .digital_mode_applied(mode_app), .tx100_range(range),
        .tx100_time_shift(shift), .tx100_slope_trim(slope), .tx100_amplitude_trim(amp100),
        .tx10_amplitude_trim(amp10), .tx10_slope_trim(slope10));
    pltc_sva pltc_sva_inst (.clk(clk), .rst(rst), .mgmt_addr(link.mgmt_addr), .mgmt_wdata(link.mgmt_wdata),
        .mgmt_wr(link.mgmt_wr), .mgmt_rd(link.mgmt_rd), .mgmt_ack(link.mgmt_ack),
        .module_reset_n(link.module_reset_n), .mac_transmit_enable(link.mac_transmit_enable),
        .mac_tx_data(link.mac_tx_data), .mac_rx_valid(link.mac_rx_valid), .mac_rx_data(link.mac_rx_data),
        .collision_out(link.collision_out));

    // ====================================================================
    // Bus and link tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mgmt(input logic w, input logic [4:0] a, input logic [15:0] wd);
        apb(1'b1, pltc_pkg::APB_WDATA, {16'h0000, wd});
        apb(1'b1, pltc_pkg::APB_CMD, {1'b1, 22'h000000, w, 3'h0, a});
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, pltc_pkg::APB_RDATA, 32'h0);
            if (r[16] === 1'b0) break;
        end
        `CMP(r[16], 1'b0)
        v = r[15:0];
    endtask
    task automatic mrd(input logic [4:0] a);
        mgmt(1'b0, a, 16'h0000);
    endtask
    task automatic unlock(input logic [15:0] commit, input logic [15:0] wd);
        mgmt(1'b1, MU, pltc_pkg::UNLOCK_KEY);
        mgmt(1'b1, WT, wd);
        mgmt(1'b1, MU, commit);
    endtask
    // Line receive stays busy in loopback, so leaked line data would show.
    task automatic frame(input int n, input logic lb, input logic ct);
        logic [3:0] nib, f;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (i >= 4) begin
                `CMP({ltx_v, ltx_pwr, ltx_d & {4{lb}}}, {~lb, ~lb, 4'h0})
                `CMP(coll, ct)
                if (!lb) `CMP({shift, slope}, {t100[range], t100[4 + 2 * int'(range) +: 2]})
            end
            if (i == 3 && !lb) `CMP(ltx_d, f ^ sa[3:0])
            nib = 4'($urandom);
            f = (i == 0) ? nib : f;
            tx_en <= 1'b1;
            tx_d <= nib;
            lrx_v <= lb;
            lrx_d <= 4'($urandom);
            if (lb) rxq.push_back(nib);
        end
        @(posedge clk);
        tx_en <= 1'b0;
        lrx_v <= 1'b0;
        repeat (6) @(posedge clk);
        `CMP(coll, 1'b0)
        `CMP(rxq.size(), 0)
    endtask
    task automatic final_report();
        if (fails == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ====================================================================
    // Clock, watchdog, receive monitor and tests
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end
    always @(posedge clk) begin
        if (rx_v === 1'b1) begin
            exp_nib = (rxq.size() > 0) ? rxq.pop_front() : 4'hx;
            `CMP(rx_d, exp_nib)
        end
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, tx_en, tx_d, lrx_v, lrx_d} = {1'b1, 53'h0};
        fails = 0;
        compares = 0;
        void'($urandom(96901));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, CT, 32'h0);
        `CMP(r[15:0], pltc_pkg::CTRL_RESET)
        apb(1'b0, 8'h20, 32'h0);
        `CMP(r, 32'h0)
        mrd(BC);
        `CMP(v, pltc_pkg::BASIC_RESET)
        m = 2'($urandom);
        sa = 5'($urandom);
        apb(1'b1, pltc_pkg::APB_ADDR, {27'h0, sa});
        apb(1'b1, CT, 32'h8000 | {30'h0, m});
        apb(1'b1, CT, 32'hc000 | {30'h0, m});
        `CMP(mode_app, m)
        apb(1'b1, CT, 32'hc000 | {30'h0, ~m});
        `CMP(mode_app, m)
        mgmt(1'b1, BC, 16'h6000);
        `CMP(loop_a, 1'b1)
        frame($urandom_range(20, 8), 1'b1, 1'b0);
        mgmt(1'b1, BC, 16'h6080);
        frame($urandom_range(20, 8), 1'b1, 1'b1);
        for (int k = 0; k < 3; k++) begin
            mgmt(1'b1, BC, 16'h2000);
            `CMP(loop_a, 1'b0)
            d = (k == 0) ? 16'hffff : 16'($urandom);
            t100 = d;
            unlock(pltc_pkg::COMMIT_TX100, d);
            mrd(WT);
            `CMP(v, d)
            `CMP(amp100, d[15:12])
            frame(12, 1'b0, 1'b0);
            unlock(pltc_pkg::COMMIT_TX10, ~d);
            `CMP({amp10, slope10}, ~d[15:12])
            mgmt(1'b1, WT, ~d);
            mgmt(1'b1, MU, pltc_pkg::UNLOCK_KEY);
            mgmt(1'b1, WT, ~d);
            mgmt(1'b1, BC, 16'h2000);
            mgmt(1'b1, MU, pltc_pkg::COMMIT_TX100);
            mrd(WT);
            `CMP(v, d)
            mgmt(1'b1, BC, 16'h2200);
            mrd(WT);
            `CMP(v, pltc_pkg::TRIM100_DEFAULT)
            `CMP({amp10, slope10}, pltc_pkg::TRIM10_DEFAULT[15:12])
            unlock(pltc_pkg::COMMIT_TX100, d);
            apb(1'b1, CT, 32'h8000 | {30'h0, ~m});
            apb(1'b1, CT, 32'hc000 | {30'h0, ~m});
            `CMP(mode_app, ~m)
            mrd(WT);
            `CMP(v, pltc_pkg::TRIM100_DEFAULT)
            mgmt(1'b1, BC, 16'h0000);
            unlock(pltc_pkg::COMMIT_TX100, d);
            mrd(WT);
            `CMP(v, pltc_pkg::TRIM100_DEFAULT)
        end
        final_report();
    end
endmodule // testbench
